// [drive_param_defines.svh]
`ifndef DRIVE_PARAM_DEFINES_SVH
`define DRIVE_PARAM_DEFINES_SVH

// Parameter numbers served on the parameter channel.
`define PNU_PCD_REQ_ASSIGN 16'h0393
`define PNU_PCD_RESP_ASSIGN 16'h0394
`define PNU_NODE_ADDRESS 16'h0396
`define PNU_WRITE_PERMIT 16'h039F
`define PNU_FAULT_HISTORY 16'h03B3
`define PNU_BAUD_RATE 16'h03C3
`define PNU_PROFILE_VERSION 16'h03C5
`define PNU_LAST_CONTROL 16'h03C7
`define PNU_LATEST_STATUS 16'h03C8
`define PNU_INIT_TRIGGER 16'h03CA

// Request codes, master to slave.
`define REQ_RD_WORD 4'h1
`define REQ_WR_WORD 4'h2
`define REQ_RD_ARRAY 4'h6
`define REQ_WR_ARRAY 4'h7
`define REQ_ARRAY_COUNT 4'h9

// Response codes, slave to master.
`define RESP_WORD_OK 4'h1
`define RESP_ARRAY_OK 4'h4
`define RESP_COUNT_OK 4'h6
`define RESP_ERROR 4'h7

// Error codes placed in the lower value word.
`define ERR_NO_PARAM 16'h0000
`define ERR_WR_INHIBIT 16'h0001
`define ERR_RANGE 16'h0002
`define ERR_BAD_INDEX 16'h0003
`define ERR_NOT_ARRAY 16'h0004
`define ERR_NOT_EXEC 16'h0011

// Fault history element indices and array sizes.
`define FAULT_IDX_LATEST 8'h01
`define FAULT_IDX_LAST 8'h09
`define FAULT_IDX_2ND 8'h11
`define FAULT_IDX_3RD 8'h19
`define FAULT_ARRAY_COUNT 16'h0019
`define PCD_ARRAY_COUNT 16'h0004
`define PCD_IDX_FIRST 8'h01
`define PCD_IDX_LAST 8'h04

// Reset and fixed values.
`define PROFILE_VERSION_VALUE 16'h0002
`define ASSIGN_RESET 16'h0000
`define WRITE_PERMIT_RESET 1'b0
`define INIT_TRIGGER_RESET 1'b0

// Timing.
`define CLK_PERIOD_NS 20
`define MS_TICK_NS 1000000
`define DELAY_STEP_MS 100

`endif

// [drive_param_pkg.sv]
package drive_param_pkg;

   typedef enum logic [2:0] {
      ST_OK = 3'b000,
      ST_WAIT = 3'b001,
      ST_RAMP = 3'b011,
      ST_TRIP = 3'b010,
      ST_IGNORE = 3'b100
   } loss_state_t;

   typedef enum logic [2:0] {
      LA_COAST_NOW,
      LA_COAST_DELAY,
      LA_COAST_CANCEL,
      LA_KEEP,
      LA_RAMP_NOW,
      LA_RAMP_DELAY,
      LA_RAMP_CANCEL
   } loss_action_t;

   typedef enum logic [2:0] {
      PK_NONE,
      PK_REQ_ASSIGN,
      PK_RESP_ASSIGN,
      PK_FAULT,
      PK_SCALAR_RO,
      PK_SCALAR_RW
   } param_kind_t;

endpackage : drive_param_pkg

// [tick_divider.sv]
`timescale 1ns/1ns
module tick_divider #(
   parameter int unsigned DIV = 50000
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Count enable and output pulse.
   input wire logic countEn,
   output logic tick
);

   logic [31:0] count;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= 32'h0000_0000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (countEn) begin
            if (count == 32'(DIV - 1)) begin
               count <= 32'h0000_0000;
               tick <= 1'b1;
            end else begin
               count <= count + 32'h0000_0001;
            end
         end
      end
   end

endmodule : tick_divider

// [drive_param_channel_comm_loss.sv]
//Contract
// - Array element read uses request code 6.
// - Good array read answers code 4, echoes.
// - Bad array index answers code 7, error 3.
// - Fault history is parameter 947, 3B3 hex.
// - Fault indices 1,9,17,25; others zero; read-only.
// - Parameter 915: four request word assignments.
// - Parameter 916: four response word assignments.
// - Parameter 927 gates writes except itself.
// - Parameter 970 falling 1 to 0 starts init.
// - No master traffic within timeout: communications error.
// - No trip before first good reception.
// - Action 0, 4-9: coast and trip immediately.
// - Action 1: wait delay, coast, trip.
// - Action 2: data cancels; else coast, trip.
// - Action 3, 13-15: run on, indicators red.
// - Action 10: ramp down, trip once stopped.
// - Action 11: wait delay, ramp, trip.
// - Action 12: data cancels; else ramp, trip.
// - Value field two words; lower word carries data.
`timescale 1ns/1ns
`include "drive_param_defines.svh"
module drive_param_channel_comm_loss
   import drive_param_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `MS_TICK_NS / `CLK_PERIOD_NS
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Parameter channel request.
   input wire logic reqValid,
   input wire logic [3:0] reqCode,
   input wire logic [15:0] reqParamNum,
   input wire logic [7:0] reqIndex,
   input wire logic [31:0] reqValue,
   // Parameter channel response.
   output logic respValid,
   output logic [3:0] respCode,
   output logic [15:0] respParamNum,
   output logic [7:0] respIndex,
   output logic [31:0] respValue,
   // Link status.
   input wire logic frameRx,
   input wire logic [15:0] watchdogTimeoutMs,
   input wire logic [6:0] nodeAddrPin,
   input wire logic [3:0] baudRateCode,
   // Drive state.
   input wire logic [15:0] faultLatest,
   input wire logic [15:0] faultLast,
   input wire logic [15:0] fault2ndLast,
   input wire logic [15:0] fault3rdLast,
   input wire logic [15:0] controlWord,
   input wire logic [15:0] statusWord,
   input wire logic motorStopped,
   // Settings.
   input wire logic [3:0] commLossAction,
   input wire logic [9:0] commLossDelay,
   output logic [63:0] pcdReqAssign,
   output logic [63:0] pcdRespAssign,
   output logic writePermit,
   output logic initTrigger,
   output logic settingsInitStart,
   // Reaction.
   output logic commError,
   output logic coastStop,
   output logic rampStop,
   output logic fieldbusFaultTrip,
   output logic powerIndicatorFlashRed,
   output logic offlineIndicatorRed
);

   function automatic param_kind_t paramKind(input logic [15:0] parameter_number);
      unique case (parameter_number)
         `PNU_PCD_REQ_ASSIGN: paramKind = PK_REQ_ASSIGN;
         `PNU_PCD_RESP_ASSIGN: paramKind = PK_RESP_ASSIGN;
         `PNU_FAULT_HISTORY: paramKind = PK_FAULT;
         `PNU_WRITE_PERMIT, `PNU_INIT_TRIGGER: paramKind = PK_SCALAR_RW;
         `PNU_NODE_ADDRESS, `PNU_BAUD_RATE, `PNU_PROFILE_VERSION,
         `PNU_LAST_CONTROL, `PNU_LATEST_STATUS: paramKind = PK_SCALAR_RO;
         default: paramKind = PK_NONE;
      endcase
   endfunction : paramKind

   function automatic loss_action_t lossAction(input logic [3:0] code);
      unique case (code)
         4'h1: lossAction = LA_COAST_DELAY;
         4'h2: lossAction = LA_COAST_CANCEL;
         4'h3, 4'hD, 4'hE, 4'hF: lossAction = LA_KEEP;
         4'hA: lossAction = LA_RAMP_NOW;
         4'hB: lossAction = LA_RAMP_DELAY;
         4'hC: lossAction = LA_RAMP_CANCEL;
         default: lossAction = LA_COAST_NOW;
      endcase
   endfunction : lossAction

   logic [15:0] reqAssign [4];
   logic [15:0] respAssign [4];
   logic [6:0] nodeAddrMeta;
   logic [6:0] nodeAddrSync;
   param_kind_t kind;
   logic [1:0] slot;
   logic isWrite;
   logic isArrCode;
   logic [3:0] next_respCode;
   logic [15:0] next_respLow;
   logic [15:0] readVal;
   logic wrReqAssign;
   logic wrRespAssign;
   logic wrPermit;
   logic wrInit;

   // The address switches are asynchronous to the drive clock.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         nodeAddrMeta <= 7'h00;
         nodeAddrSync <= 7'h00;
      end else begin
         nodeAddrMeta <= nodeAddrPin;
         nodeAddrSync <= nodeAddrMeta;
      end
   end

   assign kind = paramKind(reqParamNum);
   assign slot = 2'(reqIndex - 8'h01);
   assign isWrite = (reqCode == `REQ_WR_WORD) || (reqCode == `REQ_WR_ARRAY);
   assign isArrCode = (reqCode == `REQ_RD_ARRAY) || (reqCode == `REQ_WR_ARRAY)
      || (reqCode == `REQ_ARRAY_COUNT);

   always_comb begin
      readVal = 16'h0000;
      unique case (reqParamNum)
         `PNU_PCD_REQ_ASSIGN: readVal = reqAssign[slot];
         `PNU_PCD_RESP_ASSIGN: readVal = respAssign[slot];
         `PNU_NODE_ADDRESS: readVal = {9'h000, nodeAddrSync};
         `PNU_WRITE_PERMIT: readVal = {15'h0000, writePermit};
         `PNU_BAUD_RATE: readVal = {12'h000, baudRateCode};
         `PNU_PROFILE_VERSION: readVal = `PROFILE_VERSION_VALUE;
         `PNU_LAST_CONTROL: readVal = controlWord;
         `PNU_LATEST_STATUS: readVal = statusWord;
         `PNU_INIT_TRIGGER: readVal = {15'h0000, initTrigger};
         `PNU_FAULT_HISTORY: begin
            unique case (reqIndex)
               `FAULT_IDX_LATEST: readVal = faultLatest;
               `FAULT_IDX_LAST: readVal = faultLast;
               `FAULT_IDX_2ND: readVal = fault2ndLast;
               `FAULT_IDX_3RD: readVal = fault3rdLast;
               default: readVal = 16'h0000;
            endcase
         end
         default: readVal = 16'h0000;
      endcase
   end

   // Checks are ordered so that the most basic fault is the one reported.
   always_comb begin
      next_respCode = `RESP_ERROR;
      next_respLow = `ERR_NOT_EXEC;
      wrReqAssign = 1'b0;
      wrRespAssign = 1'b0;
      wrPermit = 1'b0;
      wrInit = 1'b0;
      if (kind == PK_NONE) begin
         next_respLow = `ERR_NO_PARAM;
      end else if (!(isArrCode || reqCode == `REQ_RD_WORD || reqCode == `REQ_WR_WORD)) begin
         next_respLow = `ERR_NOT_EXEC;
      end else if (isArrCode != (kind inside {PK_REQ_ASSIGN, PK_RESP_ASSIGN, PK_FAULT})) begin
         next_respLow = `ERR_NOT_ARRAY;
      end else if (reqCode == `REQ_ARRAY_COUNT) begin
         next_respCode = `RESP_COUNT_OK;
         next_respLow = (kind == PK_FAULT) ? `FAULT_ARRAY_COUNT : `PCD_ARRAY_COUNT;
      end else if (isWrite && !writePermit && reqParamNum != `PNU_WRITE_PERMIT) begin
         next_respLow = `ERR_WR_INHIBIT;
      end else if (isWrite && (kind inside {PK_FAULT, PK_SCALAR_RO})) begin
         next_respLow = `ERR_WR_INHIBIT;
      end else if (kind != PK_FAULT && isArrCode
                   && (reqIndex < `PCD_IDX_FIRST || reqIndex > `PCD_IDX_LAST)) begin
         next_respLow = `ERR_BAD_INDEX;
      end else if (isWrite && kind == PK_SCALAR_RW && reqValue[15:1] != 15'h0000) begin
         next_respLow = `ERR_RANGE;
      end else begin
         next_respCode = isArrCode ? `RESP_ARRAY_OK : `RESP_WORD_OK;
         next_respLow = isWrite ? reqValue[15:0] : readVal;
         wrReqAssign = isWrite && kind == PK_REQ_ASSIGN;
         wrRespAssign = isWrite && kind == PK_RESP_ASSIGN;
         wrPermit = isWrite && reqParamNum == `PNU_WRITE_PERMIT;
         wrInit = isWrite && reqParamNum == `PNU_INIT_TRIGGER;
      end
   end

   // A request code of zero means no request and draws no answer.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         respValid <= 1'b0;
         respCode <= 4'h0;
         respParamNum <= 16'h0000;
         respIndex <= 8'h00;
         respValue <= 32'h0000_0000;
      end else begin
         respValid <= reqValid && reqCode != 4'h0;
         if (reqValid && reqCode != 4'h0) begin
            respCode <= next_respCode;
            respParamNum <= reqParamNum;
            respIndex <= reqIndex;
            respValue <= {16'h0000, next_respLow};
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            reqAssign[i] <= `ASSIGN_RESET;
            respAssign[i] <= `ASSIGN_RESET;
         end
      end else if (reqValid) begin
         if (wrReqAssign) begin
            reqAssign[slot] <= reqValue[15:0];
         end
         if (wrRespAssign) begin
            respAssign[slot] <= reqValue[15:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         writePermit <= `WRITE_PERMIT_RESET;
         initTrigger <= `INIT_TRIGGER_RESET;
         settingsInitStart <= 1'b0;
      end else begin
         settingsInitStart <= 1'b0;
         if (reqValid && wrPermit) begin
            writePermit <= reqValue[0];
         end
         if (reqValid && wrInit) begin
            initTrigger <= reqValue[0];
            settingsInitStart <= initTrigger && !reqValue[0];
         end
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_assignOut
      assign pcdReqAssign[16*g +: 16] = reqAssign[g];
      assign pcdRespAssign[16*g +: 16] = respAssign[g];
   end

   logic tickMs;
   logic tickStep;
   logic [15:0] msSinceRx;
   logic commErrorDly;
   logic errRise;
   logic seenGood;
   logic [9:0] delayCnt;
   logic stopByRamp;
   loss_action_t action;
   loss_state_t state;
   loss_state_t next_state;

   tick_divider #(.DIV(MS_CYCLES)) u_msTick (
      .core_clk(core_clk),
      .rst(rst),
      .countEn(1'b1),
      .tick(tickMs)
   );

   tick_divider #(.DIV(`DELAY_STEP_MS)) u_stepTick (
      .core_clk(core_clk),
      .rst(rst),
      .countEn(tickMs),
      .tick(tickStep)
   );

   // A timeout of zero disables supervision, as the master has no watchdog.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         msSinceRx <= 16'h0000;
         commError <= 1'b0;
         commErrorDly <= 1'b0;
         seenGood <= 1'b0;
      end else begin
         commErrorDly <= commError;
         if (frameRx) begin
            msSinceRx <= 16'h0000;
            commError <= 1'b0;
            seenGood <= 1'b1;
         end else begin
            if (tickMs && msSinceRx != 16'hFFFF) begin
               msSinceRx <= msSinceRx + 16'h0001;
            end
            if (watchdogTimeoutMs != 16'h0000 && msSinceRx >= watchdogTimeoutMs) begin
               commError <= 1'b1;
            end
         end
      end
   end

   assign errRise = commError && !commErrorDly;
   assign action = lossAction(commLossAction);

   // The step tick is free running, so a delay may end up to 0.1 s early.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         delayCnt <= 10'h000;
      // Actions that do not cancel ignore data, so a frame must not stretch their wait.
      end else if (errRise || (frameRx && state == ST_WAIT
                   && (action == LA_COAST_CANCEL || action == LA_RAMP_CANCEL))) begin
         delayCnt <= commLossDelay;
      end else if (tickStep && delayCnt != 10'h000) begin
         delayCnt <= delayCnt - 10'h001;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ST_OK: begin
            if (errRise && seenGood) begin
               unique case (action)
                  LA_COAST_NOW: next_state = ST_TRIP;
                  LA_RAMP_NOW: next_state = ST_RAMP;
                  LA_KEEP: next_state = ST_IGNORE;
                  default: next_state = ST_WAIT;
               endcase
            end
         end
         ST_WAIT: begin
            if (frameRx && (action == LA_COAST_CANCEL || action == LA_RAMP_CANCEL)) begin
               next_state = ST_OK;
            end else if (delayCnt == 10'h000) begin
               if (action == LA_RAMP_DELAY || action == LA_RAMP_CANCEL) begin
                  next_state = ST_RAMP;
               end else begin
                  next_state = ST_TRIP;
               end
            end
         end
         ST_RAMP: begin
            if (motorStopped) begin
               next_state = ST_TRIP;
            end
         end
         ST_TRIP: next_state = ST_TRIP;
         ST_IGNORE: begin
            if (!commError) begin
               next_state = ST_OK;
            end
         end
         default: next_state = ST_OK;
      endcase
   end

   // The trip is held until reset; clearing a drive trip is outside this block.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= ST_OK;
         stopByRamp <= 1'b0;
         coastStop <= 1'b0;
         rampStop <= 1'b0;
         fieldbusFaultTrip <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_RAMP) begin
            stopByRamp <= 1'b1;
         end
         rampStop <= next_state == ST_RAMP || (next_state == ST_TRIP && stopByRamp);
         coastStop <= next_state == ST_TRIP && !stopByRamp && next_state != ST_RAMP;
         fieldbusFaultTrip <= next_state == ST_TRIP;
      end
   end

   assign powerIndicatorFlashRed = commError;
   assign offlineIndicatorRed = commError;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence sFaultRead(logic [7:0] idx);
      reqValid && reqCode == `REQ_RD_ARRAY && reqParamNum == `PNU_FAULT_HISTORY
         && reqIndex == idx;
   endsequence

   sequence sCoastTrip;
      coastStop && fieldbusFaultTrip;
   endsequence

   AST_FAULT_LATEST: assert property (sFaultRead(`FAULT_IDX_LATEST) |=> respValid
      && respCode == `RESP_ARRAY_OK && respValue == {16'h0000, $past(faultLatest)})
      else $error("Fault history latest read is wrong.");

   AST_FAULT_OTHER_ZERO: assert property (sFaultRead(8'h02) |=> respValid
      && respCode == `RESP_ARRAY_OK && respValue == 32'h0000_0000)
      else $error("Unlisted fault index does not read zero.");

   AST_BAD_INDEX: assert property (reqValid && reqCode == `REQ_RD_ARRAY
      && reqParamNum == `PNU_PCD_REQ_ASSIGN && reqIndex == 8'h05
      |=> respCode == `RESP_ERROR && respValue == {16'h0000, `ERR_BAD_INDEX})
      else $error("Bad array index not reported.");

   AST_WRITE_LOCK: assert property (reqValid && reqCode == `REQ_WR_ARRAY
      && reqParamNum == `PNU_PCD_REQ_ASSIGN && !writePermit
      |=> respCode == `RESP_ERROR && $stable(pcdReqAssign))
      else $error("Write went through while inhibited.");

   AST_INIT_EDGE: assert property (reqValid && reqCode == `REQ_WR_WORD
      && reqParamNum == `PNU_INIT_TRIGGER && reqValue == 32'h0000_0000
      && initTrigger && writePermit |=> settingsInitStart ##1 !settingsInitStart)
      else $error("Init trigger falling edge did not start init.");

   AST_RX_CLEARS_ERROR: assert property (frameRx |=> !commError)
      else $error("Communications error set right after data.");

   AST_NO_EARLY_TRIP: assert property (!seenGood |-> !fieldbusFaultTrip)
      else $error("Trip raised before first good reception.");

   AST_COAST_NOW: assert property (state == ST_OK && errRise && seenGood
      && action == LA_COAST_NOW |=> sCoastTrip)
      else $error("Immediate coast and trip missing.");

   AST_CANCEL: assert property (state == ST_WAIT && frameRx
      && action == LA_COAST_CANCEL |=> state == ST_OK && !fieldbusFaultTrip)
      else $error("Data within delay did not cancel the error.");

   AST_RAMP_THEN_TRIP: assert property (state == ST_RAMP && !motorStopped
      |=> !fieldbusFaultTrip && rampStop)
      else $error("Trip raised before ramp stop completed.");

endmodule : drive_param_channel_comm_loss

// [fieldbus_master_model.sv]
`timescale 1ns/1ns
module fieldbus_master_model (
   // Clock.
   input wire logic core_clk,
   // Requests and frames towards the slave.
   output logic reqValid,
   output logic [3:0] reqCode,
   output logic [15:0] reqParamNum,
   output logic [7:0] reqIndex,
   output logic [31:0] reqValue,
   output logic frameRx,
   // Answers from the slave.
   input wire logic respValid,
   input wire logic [3:0] respCode,
   input wire logic [15:0] respParamNum,
   input wire logic [7:0] respIndex,
   input wire logic [31:0] respValue
);
   logic gotValid;
   logic gotEcho;
   logic [3:0] gotCode;
   logic [31:0] gotValue;
   initial begin
      reqValid = 1'b0;
      reqCode = 4'h0;
      reqParamNum = 16'h0000;
      reqIndex = 8'h00;
      reqValue = 32'h0000_0000;
      frameRx = 1'b0;
   end
   // The answer stands one cycle only, so it is caught just after the taking edge.
   task automatic xfer(input logic [3:0] code, input logic [15:0] parameter_number, input logic [7:0] idx,
      input logic [15:0] val);
      @(posedge core_clk);
      #1;
      reqValid = 1'b1;
      reqCode = code;
      reqParamNum = parameter_number;
      reqIndex = idx;
      reqValue = {16'h0000, val};
      @(posedge core_clk);
      #1;
      gotValid = respValid;
      gotCode = respCode;
      gotValue = respValue;
      gotEcho = (respParamNum === parameter_number) && (respIndex === idx);
      // Idle fields are scrambled so that nothing can lean on a stale request.
      reqValid = 1'b0;
      reqParamNum = ~parameter_number;
      reqIndex = ~idx;
      reqValue = ~reqValue;
   endtask : xfer
   task automatic frame();
      @(posedge core_clk);
      #1;
      frameRx = 1'b1;
      @(posedge core_clk);
      #1;
      frameRx = 1'b0;
   endtask : frame
endmodule : fieldbus_master_model

// [drive_param_channel_comm_loss_test.sv]
`timescale 1ns/1ns
module drive_param_channel_comm_loss_test;
   localparam int MS = 10;
   logic core_clk, rst, reqValid, respValid, frameRx, motorStopped;
   logic [3:0] reqCode, respCode, commLossAction;
   logic [7:0] reqIndex, respIndex;
   logic [15:0] reqParamNum, respParamNum;
   logic [31:0] reqValue, respValue;
   logic [9:0] commLossDelay;
   logic [63:0] pcdReqAssign, pcdRespAssign;
   logic writePermit, initTrigger, settingsInitStart, commError, coastStop, rampStop;
   logic fieldbusFaultTrip, powerIndicatorFlashRed, offlineIndicatorRed;
   logic [15:0] flt [4] = '{16'h7511, 16'h2301, 16'h3220, 16'h4210};
   logic [15:0] control_word = 16'h047F;
   int errors = 0;
   int samplesChecked = 0;
   drive_param_channel_comm_loss #(.MS_CYCLES(MS)) uut (.core_clk(core_clk), .rst(rst),
      .reqValid(reqValid), .reqCode(reqCode), .reqParamNum(reqParamNum), .reqIndex(reqIndex),
      .reqValue(reqValue), .respValid(respValid), .respCode(respCode),
      .respParamNum(respParamNum), .respIndex(respIndex), .respValue(respValue),
      .frameRx(frameRx), .watchdogTimeoutMs(16'h0003), .nodeAddrPin(7'h05), .baudRateCode(4'h9),
      .faultLatest(flt[0]), .faultLast(flt[1]), .fault2ndLast(flt[2]), .fault3rdLast(flt[3]),
      .controlWord(control_word), .statusWord(~control_word), .motorStopped(motorStopped),
      .commLossAction(commLossAction), .commLossDelay(commLossDelay),
      .pcdReqAssign(pcdReqAssign), .pcdRespAssign(pcdRespAssign), .writePermit(writePermit),
      .initTrigger(initTrigger), .settingsInitStart(settingsInitStart), .commError(commError),
      .coastStop(coastStop), .rampStop(rampStop), .fieldbusFaultTrip(fieldbusFaultTrip),
      .powerIndicatorFlashRed(powerIndicatorFlashRed), .offlineIndicatorRed(offlineIndicatorRed));
   fieldbus_master_model master (.core_clk(core_clk), .reqValid(reqValid), .reqCode(reqCode),
      .reqParamNum(reqParamNum), .reqIndex(reqIndex), .reqValue(reqValue), .frameRx(frameRx),
      .respValid(respValid), .respCode(respCode), .respParamNum(respParamNum),
      .respIndex(respIndex), .respValue(respValue));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("comparisons=%0d mismatches=%0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic rq(input logic [3:0] code, input logic [15:0] parameter_number, input logic [7:0] idx,
      input logic [15:0] val, input logic [3:0] expCode, input logic [15:0] expVal);
      master.xfer(code, parameter_number, idx, val);
      chk({master.gotValid, master.gotEcho, master.gotCode}, {2'b11, expCode});
      chk(master.gotValue, {16'h0000, expVal});
   endtask : rq
   task automatic doRst();
      rst = 1'b1;
      motorStopped = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      rst = 1'b0;
   endtask : doRst
   task automatic t_table();
      for (int i = 0; i < 4; i++) begin
         rq(4'h6, 16'h03B3, 8'(8 * i + 1), 16'h0, 4'h4, flt[i]);
      end
      rq(4'h6, 16'h03B3, 8'h02, 16'h0, 4'h4, 16'h0);
      rq(4'h1, 16'h03C5, 8'h00, 16'h0, 4'h1, 16'h0002);
      rq(4'h1, 16'h03C7, 8'h00, 16'h0, 4'h1, control_word);
      rq(4'h1, 16'h03C8, 8'h00, 16'h0, 4'h1, 16'hFB80);
      rq(4'h1, 16'h0396, 8'h00, 16'h0, 4'h1, 16'h0005);
      rq(4'h1, 16'h03C3, 8'h00, 16'h0, 4'h1, 16'h0009);
      rq(4'h9, 16'h03B3, 8'h00, 16'h0, 4'h6, 16'h0019);
      rq(4'h1, 16'h03B3, 8'h01, 16'h0, 4'h7, 16'h0004);
      rq(4'h3, 16'h03C5, 8'h00, 16'h0, 4'h7, 16'h0011);
      rq(4'h1, 16'h0100, 8'h00, 16'h0, 4'h7, 16'h0000);
      rq(4'h2, 16'h039F, 8'h00, 16'h0002, 4'h7, 16'h0002);
      rq(4'h6, 16'h0393, 8'h05, 16'h0, 4'h7, 16'h0003);
      $display("parameter table test done");
   endtask : t_table
   task automatic t_write();
      rq(4'h7, 16'h0393, 8'h01, 16'hABCD, 4'h7, 16'h0001);
      rq(4'h2, 16'h039F, 8'h00, 16'h0001, 4'h1, 16'h0001);
      chk(writePermit, 1'b1);
      rq(4'h7, 16'h03B3, 8'h01, 16'h5555, 4'h7, 16'h0001);
      rq(4'h7, 16'h0393, 8'h01, 16'hA1A1, 4'h4, 16'hA1A1);
      rq(4'h7, 16'h0393, 8'h04, 16'hB4B4, 4'h4, 16'hB4B4);
      rq(4'h7, 16'h0394, 8'h01, 16'hC1C1, 4'h4, 16'hC1C1);
      rq(4'h6, 16'h0394, 8'h01, 16'h0, 4'h4, 16'hC1C1);
      chk(pcdReqAssign, 64'hB4B4_0000_0000_A1A1);
      rq(4'h6, 16'h0394, 8'h05, 16'h0, 4'h7, 16'h0003);
      rq(4'h7, 16'h0393, 8'h00, 16'h1111, 4'h7, 16'h0003);
      rq(4'h2, 16'h039F, 8'h00, 16'h0, 4'h1, 16'h0);
      rq(4'h7, 16'h0394, 8'h02, 16'h2222, 4'h7, 16'h0001);
      chk(pcdRespAssign, 64'h0000_0000_0000_C1C1);
      $display("write test done");
   endtask : t_write
   task automatic t_init();
      rq(4'h2, 16'h039F, 8'h00, 16'h0001, 4'h1, 16'h0001);
      rq(4'h2, 16'h03CA, 8'h00, 16'h0001, 4'h1, 16'h0001);
      chk(settingsInitStart, 1'b0);
      rq(4'h2, 16'h03CA, 8'h00, 16'h0, 4'h1, 16'h0);
      chk(settingsInitStart, 1'b1);
      $display("init test done");
   endtask : t_init
   task automatic t_first();
      doRst();
      commLossAction = 4'h0;
      repeat (100) @(posedge core_clk);
      #1;
      chk({coastStop, rampStop, fieldbusFaultTrip}, 3'b000);
      $display("first reception test done");
   endtask : t_first
   // With mid set the master keeps talking, which must cancel only the cancelling actions.
   task automatic t_loss(input logic [3:0] act, input logic [9:0] dly, input logic mid,
      input logic [2:0] early, input logic [2:0] late);
      int n;
      doRst();
      commLossAction = act;
      commLossDelay = dly;
      master.frame();
      n = 0;
      while (commError !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(n > 15 && n < 100, 1'b1);
      if (n == 100) begin
         test_done();
      end
      if (mid) begin
         master.frame();
      end
      repeat (5) @(posedge core_clk);
      #1;
      chk({powerIndicatorFlashRed, offlineIndicatorRed, commError}, {3{!mid}});
      chk({coastStop, rampStop, fieldbusFaultTrip}, early);
      motorStopped = 1'b1;
      for (int i = 0; i < 100; i++) begin
         repeat (20) @(posedge core_clk);
         if (mid) begin
            master.frame();
         end
      end
      #1;
      chk({coastStop, rampStop, fieldbusFaultTrip}, late);
      $display("loss test done, action %0d", act);
   endtask : t_loss
   initial begin
      rst = 1'b1;
      motorStopped = 1'b0;
      commLossAction = 4'h0;
      commLossDelay = 10'h0;
      doRst();
      t_table();
      t_write();
      t_init();
      t_first();
      t_loss(4'h0, 10'h0, 1'b0, 3'b101, 3'b101);
      t_loss(4'h4, 10'h2, 1'b0, 3'b101, 3'b101);
      t_loss(4'h9, 10'h2, 1'b0, 3'b101, 3'b101);
      t_loss(4'h1, 10'h2, 1'b1, 3'b000, 3'b101);
      t_loss(4'h2, 10'h2, 1'b1, 3'b000, 3'b000);
      t_loss(4'h3, 10'h0, 1'b0, 3'b000, 3'b000);
      t_loss(4'hD, 10'h0, 1'b0, 3'b000, 3'b000);
      t_loss(4'hF, 10'h0, 1'b0, 3'b000, 3'b000);
      t_loss(4'hA, 10'h2, 1'b0, 3'b010, 3'b011);
      t_loss(4'hB, 10'h2, 1'b1, 3'b000, 3'b011);
      t_loss(4'hC, 10'h2, 1'b1, 3'b000, 3'b000);
      test_done();
   end
endmodule : drive_param_channel_comm_loss_test
